// [verilog/flc_glue_regs.svh]
// Offsets, field positions, reset values and timing counts of the flash glue.
// Assumes a single 125 MHz clock; included by the glue module and the testbench.
//
// Summary of operation
// - Chip select held for whole access, secondaries low
// - Software sets page mode bit after each reset
// - Two x16 parts form one 32-bit memory
// - Transfer begin low announces next-cycle transfer
// - Output enable is inverse of transfer kind bit
// - Initial read: acks high five clocks, then low
// - Transfer ack never before address ack
// - In-page read acks two clocks after begin
// - Upper 30 address lines (31:2) detect page change
// - Write strobe low, released fifth clock after begin
// - Address ack with strobe rise, transfer ack after
// - Flash reset pulse at least 35 us
// - Hard reset at least 255 clocks, shared pulse
`ifndef FLC_GLUE_REGS_SVH
`define FLC_GLUE_REGS_SVH

// Register byte offsets
`define FLC_OFS_CTRL 8'h00
`define FLC_OFS_ADDR 8'h04
`define FLC_OFS_WDATA 8'h08
`define FLC_OFS_RDATA 8'h0c
`define FLC_OFS_STATUS 8'h10

// Control fields
`define FLC_CTRL_START 0
`define FLC_CTRL_WRITE 1
`define FLC_CTRL_RESET 2
`define FLC_CTRL_PAGE 3

// Status fields
`define FLC_STAT_BUSY 0
`define FLC_STAT_IN_RESET 1
`define FLC_STAT_PAGE 2
`define FLC_STAT_PAGE_VALID 3

// Reset values and bus answers
`define FLC_WORD_RESET 32'h0000_0000
`define FLC_RESP_OKAY 2'h0
`define FLC_RESP_DECERR 2'h3

// Timing
`define FLC_CLK_PERIOD_NS 8
`define FLC_RESET_PULSE_MIN_NS 35000
`define FLC_RESET_PULSE_MIN_CYC \
    ((`FLC_RESET_PULSE_MIN_NS + `FLC_CLK_PERIOD_NS - 1) / `FLC_CLK_PERIOD_NS)
`define FLC_HARD_RESET_MIN_CYC 255
`define FLC_RESET_HOLD_CYC ((`FLC_RESET_PULSE_MIN_CYC > `FLC_HARD_RESET_MIN_CYC) ? \
    `FLC_RESET_PULSE_MIN_CYC : `FLC_HARD_RESET_MIN_CYC)
`define FLC_RESET_EXIT_DELAY_NS 310
`define FLC_RESET_EXIT_CYC \
    ((`FLC_RESET_EXIT_DELAY_NS + `FLC_CLK_PERIOD_NS - 1) / `FLC_CLK_PERIOD_NS)
`define FLC_READ_INIT_WAIT 5
`define FLC_READ_PAGE_WAIT 1
`define FLC_WRITE_STROBE_CLK 5
`define FLC_DRAIN_CYC 2

`endif

// [verilog/flc_pkg.sv]
// Types shared by the flash glue.
// Assumes nothing beyond a SystemVerilog compiler.
package flc_pkg;

    // Access sequencer states
    typedef enum logic [2:0] {
        ST_RST_HOLD,
        ST_RST_EXIT,
        ST_IDLE,
        ST_BEGIN,
        ST_WAIT,
        ST_ACK,
        ST_DRAIN,
        ST_W_TACK
    } flc_state_t;

endpackage

// [verilog/flc_glue.sv]
// Flash wait-state glue: AXI4-Lite registers in, parallel flash pins out.
// Assumes two x16 flash parts side by side and an external pin resolver.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`include "flc_glue_regs.svh"

module flc_glue import flc_pkg::*; #(
    parameter int RESET_HOLD = `FLC_RESET_HOLD_CYC,
    parameter int EXIT_WAIT = `FLC_RESET_EXIT_CYC,
    parameter int READ_INIT_WAIT = `FLC_READ_INIT_WAIT,
    parameter int READ_PAGE_WAIT = `FLC_READ_PAGE_WAIT,
    parameter int WRITE_STROBE_CLK = `FLC_WRITE_STROBE_CLK
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Flash pins
    output logic [31:0] cpu_address_bus,
    output logic [31:0] upper_data_half_out,
    input wire logic [31:0] upper_data_half_in,
    output logic upper_data_half_oe_n,
    output logic primary_chip_select_n,
    output logic [1:0] secondary_chip_select,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_width_sel,
    output logic reset_powerdown_n,
    // Wait-state generator view
    output logic cpu_hard_reset_n,
    output logic transfer_begin_n,
    output logic transfer_kind_bit,
    output logic address_ack_n,
    output logic transfer_ack_n
);

    flc_state_t state, next_state;
    logic [15:0] cnt, next_cnt;
    logic [31:0] acc_addr, next_acc_addr, acc_wdata, next_acc_wdata;
    logic acc_write, next_acc_write, acc_inpage, next_acc_inpage;
    logic [29:0] last_page, next_last_page;
    logic page_valid, next_page_valid;
    logic [31:0] rd_data, next_rd_data;
    logic [31:0] dq_meta, dq_sync;
    logic [15:0] lim;
    logic next_ts_n, next_kind, next_cs_n, next_we_n, next_address_ack_n_n, next_ta_n;
    logic next_dq_oe_n, next_rp_n;

    // Bus-side register state
    logic [31:0] reg_addr, next_reg_addr, reg_wdata, next_reg_wdata;
    logic req_pend, next_req_pend, req_write, next_req_write;
    logic rst_pend, next_rst_pend, page_mode_bit, next_page_mode_bit;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic wr_fire, busy, take_req, take_rst;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign wr_fire = awready && wready;
    assign busy = (state != ST_IDLE) || req_pend || rst_pend;
    assign take_rst = (state == ST_IDLE) && rst_pend;
    assign take_req = (state == ST_IDLE) && !rst_pend && req_pend;

    // Bus slave and software registers; address and data are taken together
    always_comb begin
        next_awready = awvalid && wvalid && !awready && !bvalid;
        next_wready = awvalid && wvalid && !awready && !bvalid;
        next_bvalid = bvalid && !bready;
        next_bresp = bresp;
        next_arready = arvalid && !arready && !rvalid;
        next_rvalid = rvalid && !rready;
        next_rresp = rresp;
        next_rdata = rdata;
        next_reg_addr = reg_addr;
        next_reg_wdata = reg_wdata;
        next_req_write = req_write;
        next_page_mode_bit = (state == ST_RST_HOLD) ? 1'b0 : page_mode_bit;
        next_req_pend = take_req ? 1'b0 : req_pend;
        next_rst_pend = take_rst ? 1'b0 : rst_pend;
        if (wr_fire) begin
            next_bvalid = 1'b1;
            next_bresp = `FLC_RESP_OKAY;
            case (awaddr)
                `FLC_OFS_CTRL: begin
                    if (wstrb[0]) begin
                        // Start is refused while an access or reset is pending
                        if (wdata[`FLC_CTRL_START] && !busy) begin
                            next_req_pend = 1'b1;
                            next_req_write = wdata[`FLC_CTRL_WRITE];
                        end
                        // Set after the set-read-configuration command
                        if (state != ST_RST_HOLD) begin
                            next_page_mode_bit = wdata[`FLC_CTRL_PAGE];
                        end
                        next_rst_pend = next_rst_pend | wdata[`FLC_CTRL_RESET];
                    end
                end
                `FLC_OFS_ADDR: next_reg_addr = merge(reg_addr, wdata, wstrb);
                `FLC_OFS_WDATA: next_reg_wdata = merge(reg_wdata, wdata, wstrb);
                `FLC_OFS_RDATA, `FLC_OFS_STATUS: next_bresp = `FLC_RESP_OKAY;
                default: next_bresp = `FLC_RESP_DECERR;
            endcase
        end
        if (arready) begin
            next_rvalid = 1'b1;
            next_rresp = `FLC_RESP_OKAY;
            case (araddr)
                `FLC_OFS_CTRL: next_rdata = {28'h0000000, page_mode_bit, 1'b0,
                                             req_write, 1'b0};
                `FLC_OFS_ADDR: next_rdata = reg_addr;
                `FLC_OFS_WDATA: next_rdata = reg_wdata;
                `FLC_OFS_RDATA: next_rdata = rd_data;
                `FLC_OFS_STATUS: next_rdata = {28'h0000000, page_valid, page_mode_bit,
                    (state == ST_RST_HOLD) || (state == ST_RST_EXIT), busy};
                default: begin
                    next_rdata = `FLC_WORD_RESET;
                    next_rresp = `FLC_RESP_DECERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `FLC_RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rresp <= `FLC_RESP_OKAY;
            rdata <= `FLC_WORD_RESET;
            reg_addr <= `FLC_WORD_RESET;
            reg_wdata <= `FLC_WORD_RESET;
            req_write <= 1'b0;
            req_pend <= 1'b0;
            rst_pend <= 1'b0;
            page_mode_bit <= 1'b0;
        end else begin
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            reg_addr <= next_reg_addr;
            reg_wdata <= next_reg_wdata;
            req_write <= next_req_write;
            req_pend <= next_req_pend;
            rst_pend <= next_rst_pend;
            page_mode_bit <= next_page_mode_bit;
        end
    end

    // Wait-state sequencer; the count restarts at every begin
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_acc_addr = acc_addr;
        next_acc_wdata = acc_wdata;
        next_acc_write = acc_write;
        next_acc_inpage = acc_inpage;
        next_last_page = last_page;
        next_page_valid = page_valid;
        next_rd_data = rd_data;
        lim = acc_write ? 16'(WRITE_STROBE_CLK - 1) :
              (acc_inpage ? 16'(READ_PAGE_WAIT) : 16'(READ_INIT_WAIT));
        case (state)
            ST_RST_HOLD: begin
                next_page_valid = 1'b0;
                if (cnt >= 16'(RESET_HOLD - 1)) begin
                    next_state = ST_RST_EXIT;
                    next_cnt = 16'h0000;
                end else begin
                    next_cnt = cnt + 16'h0001;
                end
            end
            ST_RST_EXIT: begin
                if (cnt >= 16'(EXIT_WAIT - 1)) begin
                    next_state = ST_IDLE;
                end else begin
                    next_cnt = cnt + 16'h0001;
                end
            end
            ST_IDLE: begin
                if (take_rst) begin
                    next_state = ST_RST_HOLD;
                    next_cnt = 16'h0000;
                end else if (take_req) begin
                    next_state = ST_BEGIN;
                    next_acc_addr = reg_addr;
                    next_acc_wdata = reg_wdata;
                    next_acc_write = req_write;
                    // Same upper address lines means the page is still open
                    next_acc_inpage = !req_write && page_mode_bit && page_valid &&
                                      (reg_addr[31:2] == last_page);
                end
            end
            ST_BEGIN: begin
                next_state = ST_WAIT;
                next_cnt = 16'h0001;
            end
            ST_WAIT: begin
                if (cnt >= lim) begin
                    next_state = ST_ACK;
                end else begin
                    next_cnt = cnt + 16'h0001;
                end
            end
            ST_ACK: begin
                next_cnt = 16'h0000;
                next_state = acc_write ? ST_W_TACK : ST_DRAIN;
            end
            ST_DRAIN: begin
                // Select and enable stay low while the input synchroniser settles
                if (cnt >= 16'(`FLC_DRAIN_CYC - 1)) begin
                    next_state = ST_IDLE;
                    next_rd_data = dq_sync;
                    next_last_page = acc_addr[31:2];
                    next_page_valid = 1'b1;
                end else begin
                    next_cnt = cnt + 16'h0001;
                end
            end
            ST_W_TACK: begin
                next_state = ST_IDLE;
                next_page_valid = 1'b0;
            end
            default: begin
                next_state = ST_RST_HOLD;
                next_cnt = 16'h0000;
            end
        endcase
        // Pin values follow the next state so every output is a plain flop
        next_rp_n = (next_state != ST_RST_HOLD);
        next_ts_n = (next_state != ST_BEGIN);
        next_cs_n = (next_state == ST_IDLE) || (next_state == ST_RST_HOLD) ||
                    (next_state == ST_RST_EXIT);
        next_kind = !next_cs_n && !next_acc_write;
        next_we_n = !((next_state == ST_WAIT) && next_acc_write);
        next_address_ack_n_n = (next_state != ST_ACK);
        next_ta_n = !(((next_state == ST_ACK) && !next_acc_write) ||
                      (next_state == ST_W_TACK));
        next_dq_oe_n = !(!next_cs_n && next_acc_write);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_RST_HOLD;
            cnt <= 16'h0000;
            acc_addr <= `FLC_WORD_RESET;
            acc_wdata <= `FLC_WORD_RESET;
            acc_write <= 1'b0;
            acc_inpage <= 1'b0;
            last_page <= 30'h00000000;
            page_valid <= 1'b0;
            rd_data <= `FLC_WORD_RESET;
            dq_meta <= `FLC_WORD_RESET;
            dq_sync <= `FLC_WORD_RESET;
            cpu_address_bus <= `FLC_WORD_RESET;
            upper_data_half_out <= `FLC_WORD_RESET;
            upper_data_half_oe_n <= 1'b1;
            primary_chip_select_n <= 1'b1;
            secondary_chip_select <= 2'h0;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_width_sel <= 1'b1;
            reset_powerdown_n <= 1'b0;
            cpu_hard_reset_n <= 1'b0;
            transfer_begin_n <= 1'b1;
            transfer_kind_bit <= 1'b0;
            address_ack_n <= 1'b1;
            transfer_ack_n <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            acc_addr <= next_acc_addr;
            acc_wdata <= next_acc_wdata;
            acc_write <= next_acc_write;
            acc_inpage <= next_acc_inpage;
            last_page <= next_last_page;
            page_valid <= next_page_valid;
            rd_data <= next_rd_data;
            dq_meta <= upper_data_half_in;
            dq_sync <= dq_meta;
            cpu_address_bus <= next_acc_addr;
            upper_data_half_out <= next_acc_wdata; // Both x16 parts as one word
            upper_data_half_oe_n <= next_dq_oe_n;
            primary_chip_select_n <= next_cs_n;
            secondary_chip_select <= 2'h0;
            flash_oe_n <= !next_kind;
            flash_we_n <= next_we_n;
            flash_width_sel <= 1'b1; // x16 parts
            reset_powerdown_n <= next_rp_n;
            cpu_hard_reset_n <= next_rp_n; // Shared pulse meets both minimums
            transfer_begin_n <= next_ts_n;
            transfer_kind_bit <= next_kind;
            address_ack_n <= next_address_ack_n_n;
            transfer_ack_n <= next_ta_n;
        end
    end

    // Helper counters for the checks below
    logic [15:0] low_len, since_rise;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_len <= 16'h0000;
            since_rise <= 16'h0000;
        end else begin
            low_len <= reset_powerdown_n ? 16'h0000 : low_len + 16'h0001;
            since_rise <= !reset_powerdown_n ? 16'h0000 :
                          (since_rise == 16'hffff ? since_rise : since_rise + 16'h0001);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_begin_read_init;
        !transfer_begin_n && transfer_kind_bit && !acc_inpage;
    endsequence
    sequence s_begin_read_page;
        !transfer_begin_n && transfer_kind_bit && acc_inpage;
    endsequence
    sequence s_begin_write;
        !transfer_begin_n && !transfer_kind_bit;
    endsequence
    sequence s_both_ack;
        !address_ack_n && !transfer_ack_n;
    endsequence

    AST_OE_FOLLOWS_KIND: assert property (flash_oe_n == !transfer_kind_bit)
        else $error("Output enable is not the inverse of the kind bit");
    AST_NO_OE_IN_WRITE: assert property (!flash_we_n |-> flash_oe_n)
        else $error("Output enable active during a write");
    AST_CS_HELD: assert property (!transfer_begin_n |=> (!primary_chip_select_n)[*3])
        else $error("Chip select dropped inside an access");
    AST_READ_INIT: assert property (s_begin_read_init |=>
        (address_ack_n && transfer_ack_n)[*5] ##1 s_both_ack)
        else $error("Initial read acknowledge timing wrong");
    AST_READ_PAGE: assert property (s_begin_read_page |=>
        (address_ack_n && transfer_ack_n) ##1 s_both_ack)
        else $error("In-page read acknowledge timing wrong");
    AST_WRITE_SEQ: assert property (s_begin_write |=> (!flash_we_n && address_ack_n)[*4]
        ##1 (flash_we_n && !address_ack_n && transfer_ack_n)
        ##1 (!transfer_ack_n && address_ack_n))
        else $error("Write strobe or acknowledge timing wrong");
    AST_ACK_ORDER: assert property ($fell(transfer_ack_n) |->
        (!address_ack_n || $past(!address_ack_n)))
        else $error("Transfer ack before address ack");
    AST_RESET_PULSE: assert property ($rose(reset_powerdown_n) |->
        $past(low_len) >= 16'(RESET_HOLD - 1))
        else $error("Reset pulse too short");
    AST_EXIT_WAIT: assert property ($fell(transfer_begin_n) |->
        since_rise >= 16'(EXIT_WAIT))
        else $error("Access too soon after reset release");
    AST_IDLE_QUIET: assert property (state == ST_IDLE |->
        (address_ack_n && transfer_ack_n && flash_we_n))
        else $error("Acknowledge active while idle");
    AST_PAGE_CLEARED: assert property ($rose(reset_powerdown_n) |-> !page_mode_bit)
        else $error("Page mode bit survived a flash reset");

endmodule

// [testbench/flc_flash_model.sv]
// Behavioural model of the two x16 flash parts side by side as one 32-bit word.
// Assumes a testbench resolver that merges its output with the controller's data.
module flc_flash_model #(
    parameter logic [31:0] CFG_CMD = 32'h0060_0060 // Set-config command word, value arbitrary
) (
    // Clock for output hold
    input wire logic clk,
    // Flash pins
    input wire logic [31:0] addr,
    input wire logic [31:0] d,
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rp_n,
    input wire logic x16,
    output logic [31:0] q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:15];
    logic [31:0] last = 32'h0;
    logic page_on = 1'b0;
    logic ok_t = 1'b0;
    logic drive;
    realtime up_t = 0.0;
    // Output becomes valid only some time after the reset pin rises
    always @(posedge rp_n) up_t = $realtime;
    always @(posedge clk) ok_t <= rp_n && ($realtime - up_t >= 310.0);
    // Drives only when selected, read enabled, out of reset, in x16 mode
    assign drive = !cs_n && !oe_n && rp_n && x16 && ok_t;
    // Released bus shows the inverse so a stale value never passes
    assign q = drive ? mem[addr[5:2]] : ~last;
    always @(posedge clk) if (drive) last <= q;
    // Strobe rise latches address and data; a config command sets page mode
    always @(posedge we_n) begin
        if (!cs_n && rp_n && oe_n) begin
            if (d === CFG_CMD) page_on <= 1'b1;
            else mem[addr[5:2]] <= d;
        end
    end
    // Reset leaves page mode off
    always @(negedge rp_n) page_on <= 1'b0;
endmodule

// [testbench/test_flash_cpu_wait_state_glue.sv]
// Self-checking bench for the flash glue: AXI4-Lite master, flash model, pin monitor.
// Assumes the glue header for offsets and a shortened reset hold count.
`include "flc_glue_regs.svh"
module test_flash_cpu_wait_state_glue;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 8;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, cpu_address_bus, upper_data_half_out, upper_data_half_in, fq;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, secondary_chip_select, r;
    logic awready, wready, bvalid, arready, rvalid, upper_data_half_oe_n, primary_chip_select_n;
    logic flash_oe_n, flash_we_n, flash_width_sel, reset_powerdown_n, cpu_hard_reset_n;
    logic transfer_begin_n, transfer_kind_bit, address_ack_n, transfer_ack_n, cs_at;
    logic [31:0] shadow [0:15];
    logic [31:0] v, a;
    int errors = 0, total_checks = 0, cnt = 0, lat, tlat, wl = 0, rl = 0;
    always #4 aclk = ~aclk;
    // Shared data bus: controller wins while it drives
    assign upper_data_half_in = !upper_data_half_oe_n ? upper_data_half_out : fq;
    // Exit wait keeps its real length: the flash model withholds data for that long
    flc_glue #(.RESET_HOLD(HOLD)) dut (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .cpu_address_bus, .upper_data_half_out,
        .upper_data_half_in, .upper_data_half_oe_n, .primary_chip_select_n,
        .secondary_chip_select, .flash_oe_n, .flash_we_n, .flash_width_sel, .reset_powerdown_n,
        .cpu_hard_reset_n, .transfer_begin_n, .transfer_kind_bit, .address_ack_n,
        .transfer_ack_n);
    flc_flash_model fm (.clk(aclk), .addr(cpu_address_bus), .d(upper_data_half_out),
        .cs_n(primary_chip_select_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
        .rp_n(reset_powerdown_n), .x16(flash_width_sel), .q(fq));
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (!ok) begin
            errors++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Cycle counts from the begin pulse; stale results cleared at each begin
    always @(posedge aclk) begin
        cnt <= !transfer_begin_n ? 1 : cnt + 1;
        wl <= !transfer_begin_n ? 0 : wl + !flash_we_n;
        rl <= !transfer_begin_n ? 0 : rl + !reset_powerdown_n;
        if (!transfer_begin_n) begin
            lat <= -1;
            tlat <= -1;
        end
        if (!address_ack_n) begin
            lat <= cnt;
            cs_at <= primary_chip_select_n;
        end
        if (!transfer_ack_n) tlat <= cnt;
    end
    // Pin relations that must hold every cycle
    always @(negedge aclk) if (aresetn) begin
        chk(flash_oe_n === !transfer_kind_bit, "oe not inverse of kind");
        chk(flash_we_n === 1'b1 || flash_oe_n === 1'b1, "oe during write");
        chk(cpu_hard_reset_n === reset_powerdown_n, "hard reset differs");
        chk(secondary_chip_select === 2'h0, "secondary select");
        chk(flash_width_sel === 1'b1, "width select");
    end
    // Hang guard sized well above the whole sequence
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        $display("mismatch %0t timeout", $time);
        wrap_up();
    end
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= ad;
        awvalid <= 1;
        wdata <= d;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] ad);
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 0;
        end while (rvalid !== 1'b1);
        r = rresp;
        v = rdata;
        rready <= 0;
    endtask
    task automatic idle();
        do rd(`FLC_OFS_STATUS); while (v[`FLC_STAT_BUSY] !== 1'b0);
    endtask
    // One flash access through the registers; a read ends with RDATA in v
    task automatic acc(input logic w, input logic [31:0] ad, input logic [31:0] d, input logic pg);
        wr(`FLC_OFS_ADDR, ad);
        wr(`FLC_OFS_WDATA, d);
        wr(`FLC_OFS_CTRL, {28'h0, pg, 1'b0, w, 1'b1});
        idle();
        if (!w) rd(`FLC_OFS_RDATA);
    endtask
    // Address ack cycle after begin: write 5, initial read 6, in-page read 2
    function automatic int exp_lat(input logic w, input logic p);
        return w ? 5 : (p ? 2 : 6);
    endfunction
    task automatic ck_acc(input logic w, input logic p, input logic [31:0] ex);
        chk(lat === exp_lat(w, p), "address ack cycle");
        chk(tlat === exp_lat(w, p) + w, "transfer ack cycle");
        chk(cs_at === 1'b0, "select dropped early");
        if (w) chk(wl === 4, "strobe width");
        else chk(v === ex, "read data");
    endtask
    initial begin
        v = $urandom(32'hed441cf4);
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rd(`FLC_OFS_STATUS);
        chk(v[`FLC_STAT_IN_RESET] === 1'b1, "no reset");
        chk(reset_powerdown_n === 1'b0, "reset pin high");
        idle();
        chk(rl >= HOLD, "reset pulse short");
        // Random words written then read back with initial timing
        for (int i = 0; i < 4; i++) begin
            a = 32'($urandom_range(15, 0)) << 2;
            shadow[a[5:2]] = $urandom;
            acc(1, a, shadow[a[5:2]], 0);
            ck_acc(1, 0, 0);
            chk(fm.mem[a[5:2]] === shadow[a[5:2]], "word not latched");
            acc(0, a, 0, 0);
            ck_acc(0, 0, shadow[a[5:2]]);
        end
        // Known word at the off-page address so its read-back is not unknown
        shadow[a[5:2] ^ 4'h8] = $urandom;
        acc(1, a ^ 32'h20, shadow[a[5:2] ^ 4'h8], 0);
        // Page mode: config command, then initial, in-page and off-page reads
        acc(1, 32'h3c, 32'h0060_0060, 0);
        chk(fm.page_on === 1'b1, "config command lost");
        wr(`FLC_OFS_CTRL, 32'h8);
        rd(`FLC_OFS_STATUS);
        chk(v[`FLC_STAT_PAGE] === 1'b1, "page bit");
        acc(0, a, 0, 1);
        ck_acc(0, 0, shadow[a[5:2]]);
        acc(0, a, 0, 1);
        ck_acc(0, 1, shadow[a[5:2]]);
        acc(0, a ^ 32'h20, 0, 1);
        ck_acc(0, 0, shadow[a[5:2] ^ 4'h8]);
        // Flash reset with the page bit written high: the reset must clear it
        wr(`FLC_OFS_CTRL, 32'hc);
        idle();
        rd(`FLC_OFS_STATUS);
        chk(v[`FLC_STAT_PAGE] === 1'b0 && fm.page_on === 1'b0, "page kept");
        chk(rl >= HOLD, "flash reset short");
        acc(0, a, 0, 1);
        ck_acc(0, 0, shadow[a[5:2]]);
        // Unmapped places and register readback
        rd(8'h20);
        chk(r === `FLC_RESP_DECERR, "read decode");
        wr(8'h24, 32'h0);
        chk(r === `FLC_RESP_DECERR, "write decode");
        rd(`FLC_OFS_ADDR);
        chk(v === a && r === `FLC_RESP_OKAY, "address readback");
        wrap_up();
    end
endmodule
